//--- ptc_consts.svh
`ifndef PTC_CONSTS_SVH
`define PTC_CONSTS_SVH
`default_nettype none
`define PTC_NUM       16
`define PTC_IDX_W     4
`define PTC_VAL_W     10
`define PTC_MAX       10'h3E7
`define PTC_CLK_NS    50
`define PTC_BASE0_US  10000
`define PTC_BASE0_CYC (`PTC_BASE0_US * 1000 / `PTC_CLK_NS)
`define PTC_PRE_W     18
`define PTC_DECADE    4'h9
`define PTC_BCD_LSB   0
`define PTC_BCD_MSB   11
`define PTC_BASE_LSB  12
`define PTC_BASE_MSB  13
`define PTC_HUNDRED   11'h064
`define PTC_TEN       11'h00A
`default_nettype wire
`endif

//--- ptc_pkg.sv
`default_nettype none
package ptc_pkg;
  typedef enum logic [4:0] {
    PTC_OP_NOP,
    PTC_OP_PULSE,
    PTC_OP_EXT,
    PTC_OP_ONDLY,
    PTC_OP_STORED,
    PTC_OP_OFFDLY,
    PTC_OP_TRESET,
    PTC_OP_TSCAN,
    PTC_OP_TLOAD,
    PTC_OP_TLOADBCD,
    PTC_OP_CSET,
    PTC_OP_CRESET,
    PTC_OP_CUP,
    PTC_OP_CDOWN,
    PTC_OP_CSCAN,
    PTC_OP_CLOAD,
    PTC_OP_CLOADBCD
  } ptc_op_e;
  typedef logic [9:0] ptc_val_t;
  typedef logic [1:0] ptc_base_t;
endpackage : ptc_pkg
`default_nettype wire

//--- ptc_timer_counter.sv
// What this block does
// - timers decrement on their own tick, unrelated to the program scan
// - expiry seen by the program only at the next scan operation
// - all timer modes except reset start on a logic result edge only
// - started timer counts down one per base tick, stops at zero
// - a start edge while running reloads the initial value and restarts, except in stored on-delay
// - timing uncertainty at most one base period
// - each timer gives one state bit for boolean scans
// - stored on-delay ignores start input changes once started
// - timer reset restores the initial value and forces the state low
// - on-delay output high after delay, only while start input stays one
// - off-delay output falls only after the delay past the falling edge
// - counters hold three decimal digits, 0 to 999
// - set loads the preset on a rising logic result
// - the preset comes from the primary accumulator
// - counter reset holds zero while the logic result is one
// - count-up adds one per rising edge, steady level changes nothing
// - count-down subtracts one per rising edge, steady level changes nothing
// - preset word is BCD, top four bits ignored
// - counter scan is one whenever the count is nonzero
// - timer load returns remaining time, binary or BCD
// - counter load returns the count, binary or BCD
// - time word: three BCD digits plus two-bit base, top two bits ignored
// - base codes 0..3 give 0.01 s, 0.1 s, 1 s, 10 s ticks
// - off-delay with logic result one holds the initial value
`timescale 1ns/1ps
`include "ptc_consts.svh"
`default_nettype none
module ptc_timer_counter #(
  parameter int unsigned BASE0_CYCLES = `PTC_BASE0_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    op_valid,
  input  wire ptc_pkg::ptc_op_e        op_code,
  input  wire logic [`PTC_IDX_W-1:0]   op_idx,
  input  wire logic                    logic_result_bit,
  input  wire logic [15:0]             primary_accumulator,
  output logic [15:0]                  load_word_r,
  output logic                         load_valid_r,
  output logic                         state_bit_r,
  output logic                         state_valid_r
);
  import ptc_pkg::*;

  function automatic ptc_val_t bcd2bin(input logic [11:0] b);
    logic [10:0] s;
    s = 11'(b[11:8]) * `PTC_HUNDRED + 11'(b[7:4]) * `PTC_TEN + 11'(b[3:0]);
    return (s > 11'(`PTC_MAX)) ? `PTC_MAX : s[9:0];
  endfunction : bcd2bin

  function automatic logic [11:0] bin2bcd(input ptc_val_t v);
    logic [10:0] h;
    logic [10:0] t;
    logic [10:0] o;
    h = 11'(v) / `PTC_HUNDRED;
    t = (11'(v) % `PTC_HUNDRED) / `PTC_TEN;
    o = 11'(v) % `PTC_TEN;
    return {h[3:0], t[3:0], o[3:0]};
  endfunction : bin2bcd

  function automatic logic tmr_state(input ptc_op_e m, input logic run, input logic done, input logic lvl);
    unique case (m)
      PTC_OP_PULSE, PTC_OP_EXT: return run;
      PTC_OP_ONDLY:             return done & lvl;
      PTC_OP_STORED:            return done;
      PTC_OP_OFFDLY:            return lvl | run;
      default:                  return 1'b0;
    endcase
  endfunction : tmr_state

  // time base prescalers
  logic [`PTC_PRE_W-1:0] pre0_r;
  logic [3:0]            ticks;

  assign ticks[0] = (pre0_r == `PTC_PRE_W'(BASE0_CYCLES - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre0_r <= '0;
    end else if (ticks[0]) begin
      pre0_r <= '0;
    end else begin
      pre0_r <= pre0_r + 1'b1;
    end
  end

  genvar k;
  generate
    for (k = 1; k < 4; k++) begin : g_dec
      logic [3:0] dec_r;
      assign ticks[k] = ticks[k-1] & (dec_r == `PTC_DECADE);
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          dec_r <= '0;
        end else if (ticks[k]) begin
          dec_r <= '0;
        end else if (ticks[k-1]) begin
          dec_r <= dec_r + 1'b1;
        end
      end
    end
  endgenerate

  // timer bank
  ptc_val_t  tmr_val  [`PTC_NUM];
  ptc_val_t  tmr_ini  [`PTC_NUM];
  ptc_base_t tmr_base [`PTC_NUM];
  ptc_op_e   tmr_mode [`PTC_NUM];
  logic      tmr_run  [`PTC_NUM];
  logic      tmr_done [`PTC_NUM];
  logic      tmr_lvl  [`PTC_NUM];

  ptc_val_t  acc_val;
  ptc_base_t acc_base;
  logic      lres;
  logic      t_lvl;
  logic      t_edge_op;
  logic      t_start;
  logic      t_hold;
  logic      t_stop;
  logic      t_rst;

  assign lres     = logic_result_bit;
  assign acc_val  = bcd2bin(primary_accumulator[`PTC_BCD_MSB:`PTC_BCD_LSB]);
  assign acc_base = primary_accumulator[`PTC_BASE_MSB:`PTC_BASE_LSB];
  assign t_lvl    = tmr_lvl[op_idx];

  always_comb begin
    t_edge_op = 1'b0;
    t_start   = 1'b0;
    t_hold    = 1'b0;
    t_stop    = 1'b0;
    t_rst     = 1'b0;
    if (op_valid) begin
      unique case (op_code)
        PTC_OP_PULSE, PTC_OP_ONDLY: begin
          t_edge_op = 1'b1;
          t_start   = lres & ~t_lvl;
          t_stop    = ~lres;
        end
        PTC_OP_EXT: begin
          t_edge_op = 1'b1;
          t_start   = lres & ~t_lvl;
        end
        PTC_OP_STORED: begin
          t_edge_op = 1'b1;
          // started or expired: input changes are ignored until reset
          t_start   = lres & ~t_lvl & ~tmr_run[op_idx] & ~tmr_done[op_idx];
        end
        PTC_OP_OFFDLY: begin
          t_edge_op = 1'b1;
          t_hold    = lres;
          t_start   = ~lres & t_lvl;
        end
        PTC_OP_TRESET: t_rst = lres;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `PTC_NUM; i++) begin
        tmr_val[i]  <= '0;
        tmr_ini[i]  <= '0;
        tmr_base[i] <= '0;
        tmr_mode[i] <= PTC_OP_NOP;
        tmr_run[i]  <= 1'b0;
        tmr_done[i] <= 1'b0;
        tmr_lvl[i]  <= 1'b0;
      end
    end else begin
      for (int i = 0; i < `PTC_NUM; i++) begin
        // free-running base: first tick lands anywhere within one period
        if (tmr_run[i] && ticks[tmr_base[i]]) begin
          tmr_val[i] <= tmr_val[i] - 1'b1;
          if (tmr_val[i] == 10'h001) begin
            tmr_run[i]  <= 1'b0;
            tmr_done[i] <= 1'b1;
          end
        end
        if (op_valid && op_idx == `PTC_IDX_W'(i)) begin
          if (t_edge_op) begin
            tmr_lvl[i] <= lres;
          end
          if (t_start || t_hold) begin
            tmr_val[i]  <= acc_val;
            tmr_ini[i]  <= acc_val;
            tmr_base[i] <= acc_base;
            tmr_mode[i] <= op_code;
            tmr_run[i]  <= t_start & (acc_val != '0);
            tmr_done[i] <= t_start & (acc_val == '0);
          end else if (t_stop) begin
            tmr_run[i]  <= 1'b0;
            tmr_done[i] <= 1'b0;
          end else if (t_rst) begin
            tmr_val[i]  <= tmr_ini[i];
            tmr_run[i]  <= 1'b0;
            tmr_done[i] <= 1'b0;
            tmr_lvl[i]  <= 1'b0;
          end
        end
      end
    end
  end

  // counter bank
  ptc_val_t cnt_val [`PTC_NUM];
  logic     cnt_ls  [`PTC_NUM];
  logic     cnt_lu  [`PTC_NUM];
  logic     cnt_ld  [`PTC_NUM];
  ptc_val_t cnt_sel;
  logic     c_hit;

  assign cnt_sel = cnt_val[op_idx];
  assign c_hit   = op_valid & lres;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `PTC_NUM; i++) begin
        cnt_val[i] <= '0;
        cnt_ls[i]  <= 1'b0;
        cnt_lu[i]  <= 1'b0;
        cnt_ld[i]  <= 1'b0;
      end
    end else if (op_valid) begin
      unique case (op_code)
        PTC_OP_CSET: begin
          cnt_ls[op_idx] <= lres;
          if (c_hit && !cnt_ls[op_idx]) begin
            cnt_val[op_idx] <= acc_val;
          end
        end
        PTC_OP_CRESET: begin
          if (c_hit) begin
            cnt_val[op_idx] <= '0;
          end
        end
        PTC_OP_CUP: begin
          cnt_lu[op_idx] <= lres;
          if (c_hit && !cnt_lu[op_idx] && cnt_sel != `PTC_MAX) begin
            cnt_val[op_idx] <= cnt_sel + 1'b1;
          end
        end
        PTC_OP_CDOWN: begin
          cnt_ld[op_idx] <= lres;
          if (c_hit && !cnt_ld[op_idx] && cnt_sel != '0) begin
            cnt_val[op_idx] <= cnt_sel - 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // scan and load answers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      load_word_r   <= '0;
      load_valid_r  <= 1'b0;
      state_bit_r   <= 1'b0;
      state_valid_r <= 1'b0;
    end else begin
      load_valid_r  <= 1'b0;
      state_valid_r <= 1'b0;
      if (op_valid) begin
        unique case (op_code)
          PTC_OP_TSCAN: begin
            // sampled here only, so an expiry waits for the next scan
            state_bit_r   <= tmr_state(tmr_mode[op_idx], tmr_run[op_idx],
                                       tmr_done[op_idx], tmr_lvl[op_idx]);
            state_valid_r <= 1'b1;
          end
          PTC_OP_CSCAN: begin
            state_bit_r   <= (cnt_sel != '0);
            state_valid_r <= 1'b1;
          end
          PTC_OP_TLOAD: begin
            load_word_r  <= {6'h00, tmr_val[op_idx]};
            load_valid_r <= 1'b1;
          end
          PTC_OP_TLOADBCD: begin
            load_word_r  <= {2'b00, tmr_base[op_idx], bin2bcd(tmr_val[op_idx])};
            load_valid_r <= 1'b1;
          end
          PTC_OP_CLOAD: begin
            load_word_r  <= {6'h00, cnt_sel};
            load_valid_r <= 1'b1;
          end
          PTC_OP_CLOADBCD: begin
            load_word_r  <= {4'h0, bin2bcd(cnt_sel)};
            load_valid_r <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic tmr_sel_run;
  assign tmr_sel_run = tmr_run[op_idx];

  property p_cnt_range;
    cnt_sel <= `PTC_MAX;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("counter above 999");

  property p_cnt_up;
    op_valid && op_code == PTC_OP_CUP && lres && !cnt_lu[op_idx] && cnt_sel < `PTC_MAX
      |=> cnt_val[$past(op_idx)] == $past(cnt_sel) + 1'b1;
  endproperty
  a_cnt_up: assert property (p_cnt_up) else $error("count up did not add one");

  property p_cnt_dn_steady;
    op_valid && op_code == PTC_OP_CDOWN && lres && cnt_ld[op_idx]
      |=> cnt_val[$past(op_idx)] == $past(cnt_sel);
  endproperty
  a_cnt_dn_steady: assert property (p_cnt_dn_steady) else $error("count down on steady level");

  property p_cnt_rst;
    op_valid && op_code == PTC_OP_CRESET && lres |=> cnt_val[$past(op_idx)] == '0;
  endproperty
  a_cnt_rst: assert property (p_cnt_rst) else $error("reset did not zero counter");

  property p_cnt_set;
    op_valid && op_code == PTC_OP_CSET && lres && !cnt_ls[op_idx]
      |=> cnt_val[$past(op_idx)] == $past(acc_val);
  endproperty
  a_cnt_set: assert property (p_cnt_set) else $error("set did not load preset");

  property p_cnt_scan;
    op_valid && op_code == PTC_OP_CSCAN |=> state_valid_r && state_bit_r == ($past(cnt_sel) != '0);
  endproperty
  a_cnt_scan: assert property (p_cnt_scan) else $error("counter scan wrong");

  property p_tmr_rst;
    op_valid && op_code == PTC_OP_TRESET && lres
      |=> !tmr_run[$past(op_idx)] && tmr_val[$past(op_idx)] == tmr_ini[$past(op_idx)];
  endproperty
  a_tmr_rst: assert property (p_tmr_rst) else $error("timer reset failed");

  property p_tmr_level;
    op_valid && op_code == PTC_OP_PULSE && lres && t_lvl && !tmr_sel_run |=> !tmr_run[$past(op_idx)];
  endproperty
  a_tmr_level: assert property (p_tmr_level) else $error("timer started on level");

  property p_tmr_nonzero;
    tmr_sel_run |-> tmr_val[op_idx] != '0;
  endproperty
  a_tmr_nonzero: assert property (p_tmr_nonzero) else $error("timer runs at zero");

  property p_tick_gap;
    ticks[0] |=> !ticks[0] [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("base tick too frequent");

  c_tmr_start: cover property (op_valid && op_code == PTC_OP_ONDLY && t_start);
  c_tmr_expire: cover property (tmr_sel_run ##1 !tmr_sel_run);
  c_cnt_up: cover property (op_valid && op_code == PTC_OP_CUP && lres && !cnt_lu[op_idx]);
  c_load_bcd: cover property (op_valid && op_code == PTC_OP_TLOADBCD);
endmodule : ptc_timer_counter
`default_nettype wire

//--- ptc_engine.sv
`timescale 1ns/1ps
`default_nettype none
module ptc_engine (
  input  wire logic         clk,
  output logic              op_valid,
  output ptc_pkg::ptc_op_e  op_code,
  output logic [3:0]        op_idx,
  output logic              logic_result_bit,
  output logic [15:0]       primary_accumulator,
  input  wire logic [15:0]  load_word_r,
  input  wire logic         load_valid_r,
  input  wire logic         state_bit_r,
  input  wire logic         state_valid_r
);
  import ptc_pkg::*;
  initial begin
    op_valid = 1'b0;
    op_code = PTC_OP_NOP;
    op_idx = 4'h0;
    logic_result_bit = 1'b0;
    primary_accumulator = 16'h0000;
  end
  // one op per two edges, so valid is never driven twice in one time slot
  task automatic issue(input ptc_op_e c, input int i, input logic r, input logic [15:0] a,
                       output logic [15:0] ans);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_idx <= 4'(i);
    logic_result_bit <= r;
    primary_accumulator <= a;
    @(posedge clk);
    op_valid <= 1'b0;
    // released lines flip so a stale value cannot pass
    logic_result_bit <= ~r;
    primary_accumulator <= ~a;
    #1;
    ans = load_valid_r ? load_word_r : (state_valid_r ? {15'h0000, state_bit_r} : 16'hffff);
  endtask : issue
endmodule : ptc_engine
`default_nettype wire

//--- ptc_timer_counter_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ptc_timer_counter_bench;
  import ptc_pkg::*;
  localparam int unsigned B0 = 10;
  logic        clk, resetn, op_valid, lres, load_valid_r, state_bit_r, state_valid_r;
  ptc_op_e     op_code;
  logic [3:0]  op_idx;
  logic [15:0] acc, load_word_r, ans;
  int          num_errors = 0, compares = 0;
  int          cnt[16];
  bit          ms[16], mu[16], md[16];

  ptc_timer_counter #(.BASE0_CYCLES(B0)) DUT (.clk(clk), .resetn(resetn), .op_valid(op_valid),
    .op_code(op_code), .op_idx(op_idx), .logic_result_bit(lres), .primary_accumulator(acc),
    .load_word_r(load_word_r), .load_valid_r(load_valid_r), .state_bit_r(state_bit_r),
    .state_valid_r(state_valid_r));
  ptc_engine eng (.clk(clk), .op_valid(op_valid), .op_code(op_code), .op_idx(op_idx),
    .logic_result_bit(lres), .primary_accumulator(acc), .load_word_r(load_word_r),
    .load_valid_r(load_valid_r), .state_bit_r(state_bit_r), .state_valid_r(state_valid_r));

  always #25 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  function automatic logic [15:0] bcd(input int v);
    return 16'(((v / 100) << 8) | (((v / 10) % 10) << 4) | (v % 10));
  endfunction : bcd

  // time word with random ignored top bits
  function automatic logic [15:0] tw(input int v, input int b);
    logic [15:0] w;
    w = bcd(v);
    w[13:12] = 2'(b);
    w[15:14] = 2'($urandom);
    return w;
  endfunction : tw

  task automatic op(input ptc_op_e c, input int i, input logic r, input logic [15:0] a);
    eng.issue(c, i, r, a, ans);
  endtask : op

  task automatic scan_is(input int i, input logic [15:0] e);
    op(PTC_OP_TSCAN, i, 1'b0, 16'h0000);
    check(ans, e);
  endtask : scan_is

  task automatic cnt_round(input int i);
    int k, v;
    logic r;
    logic [15:0] w;
    k = $urandom_range(3);
    r = 1'($urandom_range(1));
    v = ($urandom_range(3) == 0) ? 999 : $urandom_range(999);
    w = bcd(v);
    w[15:12] = 4'($urandom);
    case (k)
      0: begin
        op(PTC_OP_CSET, i, r, w);
        if (r && !ms[i]) cnt[i] = v;
        ms[i] = r;
      end
      1: begin
        op(PTC_OP_CRESET, i, r, w);
        if (r) cnt[i] = 0;
      end
      2: begin
        op(PTC_OP_CUP, i, r, w);
        if (r && !mu[i] && cnt[i] < 999) cnt[i]++;
        mu[i] = r;
      end
      default: begin
        op(PTC_OP_CDOWN, i, r, w);
        if (r && !md[i] && cnt[i] > 0) cnt[i]--;
        md[i] = r;
      end
    endcase
    op(PTC_OP_CSCAN, i, r, w);
    check(ans, {15'h0000, cnt[i] != 0});
    op(PTC_OP_CLOAD, i, r, w);
    check(ans, 16'(cnt[i]));
    op(PTC_OP_CLOADBCD, i, r, w);
    check(ans, bcd(cnt[i]));
  endtask : cnt_round

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    void'($urandom(28315));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    // few counters so saturation and edges repeat often
    repeat (300) cnt_round($urandom_range(3));
    $display("counter test done");
    op(PTC_OP_ONDLY, 0, 1'b0, tw(3, 0));
    op(PTC_OP_ONDLY, 0, 1'b1, tw(3, 0));
    scan_is(0, 16'h0000);
    repeat (40) @(posedge clk);
    scan_is(0, 16'h0001);
    op(PTC_OP_ONDLY, 0, 1'b1, tw(3, 0));
    scan_is(0, 16'h0001);
    op(PTC_OP_TLOAD, 0, 1'b0, 16'h0000);
    check(ans, 16'h0000);
    op(PTC_OP_ONDLY, 0, 1'b0, tw(3, 0));
    scan_is(0, 16'h0000);
    $display("on-delay test done");
    op(PTC_OP_STORED, 2, 1'b0, tw(3, 0));
    op(PTC_OP_STORED, 2, 1'b1, tw(3, 0));
    repeat (40) @(posedge clk);
    op(PTC_OP_STORED, 2, 1'b0, tw(9, 1));
    op(PTC_OP_STORED, 2, 1'b1, tw(9, 1));
    scan_is(2, 16'h0001);
    op(PTC_OP_TRESET, 2, 1'b1, tw(9, 1));
    scan_is(2, 16'h0000);
    op(PTC_OP_TLOAD, 2, 1'b0, 16'h0000);
    check(ans, 16'h0003);
    $display("stored on-delay test done");
    op(PTC_OP_OFFDLY, 3, 1'b1, tw(4, 0));
    repeat (30) @(posedge clk);
    op(PTC_OP_TLOAD, 3, 1'b1, 16'h0000);
    check(ans, 16'h0004);
    op(PTC_OP_OFFDLY, 3, 1'b0, tw(4, 0));
    scan_is(3, 16'h0001);
    repeat (50) @(posedge clk);
    scan_is(3, 16'h0000);
    $display("off-delay test done");
    op(PTC_OP_EXT, 4, 1'b0, tw(5, 0));
    op(PTC_OP_EXT, 4, 1'b1, tw(5, 0));
    repeat (30) @(posedge clk);
    op(PTC_OP_EXT, 4, 1'b0, tw(5, 0));
    op(PTC_OP_EXT, 4, 1'b1, tw(5, 0));
    op(PTC_OP_TLOAD, 4, 1'b0, 16'h0000);
    check({15'h0000, ans == 16'h0005 || ans == 16'h0004}, 16'h0001);
    scan_is(4, 16'h0001);
    for (int b = 0; b < 4; b++) begin
      op(PTC_OP_PULSE, 5 + b, 1'b0, tw(7, b));
      op(PTC_OP_PULSE, 5 + b, 1'b1, tw(7, b));
      op(PTC_OP_TLOADBCD, 5 + b, 1'b0, 16'h0000);
      check({12'h000, ans[15:12]}, 16'(b));
      scan_is(5 + b, 16'h0001);
    end
    // expired pulse timer must not restart on a steady one
    repeat (80) @(posedge clk);
    op(PTC_OP_PULSE, 5, 1'b1, tw(7, 0));
    scan_is(5, 16'h0000);
    $display("restart and base test done");
    give_verdict();
  end

  // about 2800 cycles expected; cut off far beyond
  initial begin
    #(50 * 40000);
    num_errors++;
    give_verdict();
  end
endmodule : ptc_timer_counter_bench
`default_nettype wire
